// File: clock_gate_regs.vh
`ifndef CLOCK_GATE_REGS_VH
`define CLOCK_GATE_REGS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define RUN_CLOCK_CONFIG_OFS     12'h060
`define RUN_PORT_GATE_OFS        12'h108
`define SLEEP_PORT_GATE_OFS      12'h118
`define DEEP_PORT_GATE_OFS       12'h128
`define RUN_SERIAL_GATE_OFS      12'h10C
`define SLEEP_SERIAL_GATE_OFS    12'h11C
`define DEEP_SERIAL_GATE_OFS     12'h12C
`define IRQ_STATUS_OFS           12'h200
`define IRQ_MASK_OFS             12'h204

// ****************************************
// Fields and reset values
// ****************************************
`define AUTO_CLOCK_GATING_BIT    0
`define PORT_GATE_MASK           8'hFF
`define SERIAL_GATE_MASK         16'h5137
`define PORT_GATE_RESET          8'h00
`define SERIAL_GATE_RESET        16'h0000
`define CONFIG_RESET             1'b0
`define IRQ_BITS                 2
`define IRQ_RESET                2'h0
`define IRQ_ACCESS_FAULT_BIT     0
`define IRQ_GATE_CHANGE_BIT      1
`define UNIT_COUNT               24
`define UNIT_ID_WIDTH            5

`endif

// File: gate_select.v
`timescale 1ns/1ps
`include "clock_gate_regs.vh"

module gate_select
(
    input  wire                     clk,
    input  wire                     rst,
    input  wire                     sleep_mode,
    input  wire                     deep_sleep_mode,
    input  wire                     auto_clock_gating,
    input  wire [`UNIT_COUNT-1:0]   run_gate,
    input  wire [`UNIT_COUNT-1:0]   sleep_gate,
    input  wire [`UNIT_COUNT-1:0]   deep_gate,
    output reg  [`UNIT_COUNT-1:0]   unit_en_q,
    output reg                      changed_q
);

    reg [`UNIT_COUNT-1:0] unit_en_d;

    always @*
    begin
        unit_en_d = run_gate;                            // [R6]
        if (auto_clock_gating && deep_sleep_mode)
            unit_en_d = deep_gate;                       // [R4] [R5]
        else if (auto_clock_gating && sleep_mode)
            unit_en_d = sleep_gate;                      // [R4] [R5]
    end

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            unit_en_q <= {`UNIT_COUNT{1'b0}};            // [R3]
            changed_q <= 1'b0;
        end
        else
        begin
            unit_en_q <= unit_en_d;                      // [R1]
            changed_q <= (unit_en_d != unit_en_q);
        end
    end

endmodule // gate_select

// File: access_check.v
`timescale 1ns/1ps
`include "clock_gate_regs.vh"

module access_check
(
    input  wire                       clk,
    input  wire                       rst,
    input  wire [`UNIT_COUNT-1:0]     unit_en,
    input  wire                       req,
    input  wire [`UNIT_ID_WIDTH-1:0]  unit_id,
    output reg                        fault_q,
    output reg                        done_q
);

    wire in_range;
    wire enabled;

    assign in_range = (unit_id < `UNIT_COUNT);
    assign enabled  = in_range && unit_en[unit_id];

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            fault_q <= 1'b0;
            done_q  <= 1'b0;
        end
        else
        begin
            fault_q <= req && !enabled;                  // [R2]
            done_q  <= req && enabled;
        end
    end

endmodule // access_check

// File: clock_gate_ctrl.v
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "clock_gate_regs.vh"

// Operation
// R1 - Each gate bit is the clock enable of one unit: set runs it, clear stops and disables it.
// R2 - An access to a unit whose gate is clear ends in a bus fault, not a normal completion.
// R3 - Reset clears every gate bit so all units start unclocked.
// R4 - The run gates apply while running, sleep gates in sleep, deep-sleep gates in deep sleep.
// R5 - Sleep and deep-sleep gates are used only when the auto clock gating bit is set.
// R6 - With auto clock gating clear, the run gates stay in force in both low-power modes.
// R7 - Port gate register bits 31 to 8 are read-only zero; software keeps them on updates.
// R8 - Port gate register bits 7 to 0 are read/write and gate ports H down to A.
// R9 - Serial gate register bit 14 gates two-wire module 1 and bit 12 two-wire module 0.
// R10 - Serial gate register bit 8 gates the quadrature encoder.
// R11 - Serial gate register bits 5 and 4 gate synchronous serial modules 1 and 0.
// R12 - Serial gate register bits 2, 1 and 0 gate asynchronous serial modules 2, 1 and 0.
// R13 - Serial gate register bits 15, 13, 11 to 9, 7 to 6 and 3 are read-only zero.
module clock_gate_ctrl
(
    input  wire                       CLK_SYS,
    input  wire                       RST,
    input  wire                       HSEL,
    input  wire [31:0]                HADDR,
    input  wire [1:0]                 HTRANS,
    input  wire                       HWRITE,
    input  wire [2:0]                 HSIZE,
    input  wire [31:0]                HWDATA,
    input  wire                       HREADY,
    output reg  [31:0]                HRDATA,
    output wire                       HREADYOUT,
    output wire                       HRESP,
    input  wire                       SLEEP_MODE,
    input  wire                       DEEP_SLEEP_MODE,
    input  wire                       UNIT_REQ,
    input  wire [`UNIT_ID_WIDTH-1:0]  UNIT_ID,
    output wire                       UNIT_FAULT,
    output wire                       UNIT_DONE,
    output wire [7:0]                 PORT_CLK_EN,
    output wire                       TWO_WIRE_0_CLK_EN,
    output wire                       TWO_WIRE_1_CLK_EN,
    output wire                       QUAD_ENC_CLK_EN,
    output wire                       SYNC_SERIAL_0_CLK_EN,
    output wire                       SYNC_SERIAL_1_CLK_EN,
    output wire                       ASYNC_SERIAL_0_CLK_EN,
    output wire                       ASYNC_SERIAL_1_CLK_EN,
    output wire                       ASYNC_SERIAL_2_CLK_EN,
    output wire                       IRQ
);

    // ****************************************
    // Bus slave state
    // ****************************************
    // One-hot bus phase states
    localparam [3:0] ST_IDLE      = 4'b0001;
    localparam [3:0] ST_WRITE     = 4'b0010;
    localparam [3:0] ST_READ_WAIT = 4'b0100;
    localparam [3:0] ST_READ_DATA = 4'b1000;

    reg  [3:0]  state_q;
    reg  [3:0]  state_d;
    reg  [11:0] addr_q;
    reg  [31:0] rd_data_d;

    wire        take;
    wire        wr_go;
    wire        rd_wait;

    // Gate storage: index 0 run, 1 sleep, 2 deep sleep
    reg  [7:0]  port_gate_q  [0:2];
    reg  [15:0] serial_gate_q [0:2];
    reg         auto_clock_gating_q;
    reg  [`IRQ_BITS-1:0] irq_status_q;
    reg  [`IRQ_BITS-1:0] irq_mask_q;
    reg  [`IRQ_BITS-1:0] irq_event;

    wire [`UNIT_COUNT-1:0] unit_en;
    wire        gate_changed;
    wire        fault;

    // ****************************************
    // AHB-Lite address and data phase
    // ****************************************
    assign take      = HSEL && HTRANS[1] && HREADY;
    assign wr_go     = (state_q == ST_WRITE);
    assign rd_wait   = (state_q == ST_READ_WAIT);
    assign HREADYOUT = !rd_wait;
    assign HRESP     = 1'b0;

    // Reads take one wait state so a write just before is already visible
    always @*
    begin
        state_d = ST_IDLE;
        case (state_q)
            ST_READ_WAIT:
                state_d = ST_READ_DATA;
            ST_IDLE, ST_WRITE, ST_READ_DATA:
            begin
                if (take && HWRITE)
                    state_d = ST_WRITE;
                else if (take)
                    state_d = ST_READ_WAIT;
            end
            default:
                state_d = ST_IDLE;
        endcase
    end

    always @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            state_q <= ST_IDLE;
            addr_q  <= 12'h000;
        end
        else
        begin
            state_q <= state_d;
            if (take && !rd_wait)
                addr_q <= HADDR[11:0];
        end
    end

    // ****************************************
    // Read mux
    // ****************************************
    always @*
    begin
        rd_data_d = 32'h00000000;
        case (addr_q)
            `RUN_CLOCK_CONFIG_OFS:
                rd_data_d[`AUTO_CLOCK_GATING_BIT] = auto_clock_gating_q;
            `RUN_PORT_GATE_OFS:
                rd_data_d[7:0] = port_gate_q[0];               // [R7] [R8]
            `SLEEP_PORT_GATE_OFS:
                rd_data_d[7:0] = port_gate_q[1];
            `DEEP_PORT_GATE_OFS:
                rd_data_d[7:0] = port_gate_q[2];
            `RUN_SERIAL_GATE_OFS:
                rd_data_d[15:0] = serial_gate_q[0];            // [R13]
            `SLEEP_SERIAL_GATE_OFS:
                rd_data_d[15:0] = serial_gate_q[1];
            `DEEP_SERIAL_GATE_OFS:
                rd_data_d[15:0] = serial_gate_q[2];
            `IRQ_STATUS_OFS:
                rd_data_d[`IRQ_BITS-1:0] = irq_status_q;
            `IRQ_MASK_OFS:
                rd_data_d[`IRQ_BITS-1:0] = irq_mask_q;
            default:
                rd_data_d = 32'h00000000;
        endcase
    end

    always @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
            HRDATA <= 32'h00000000;
        else if (rd_wait)
            HRDATA <= rd_data_d;
    end

    // ****************************************
    // Gate registers, one per mode
    // ****************************************
    genvar k;
    generate
        for (k = 0; k < 3; k = k + 1)
        begin : g_mode
            wire [11:0] port_ofs;
            wire [11:0] serial_ofs;
            assign port_ofs   = (k == 0) ? `RUN_PORT_GATE_OFS :
                                (k == 1) ? `SLEEP_PORT_GATE_OFS : `DEEP_PORT_GATE_OFS;
            assign serial_ofs = (k == 0) ? `RUN_SERIAL_GATE_OFS :
                                (k == 1) ? `SLEEP_SERIAL_GATE_OFS : `DEEP_SERIAL_GATE_OFS;
            always @(posedge CLK_SYS or posedge RST)
            begin
                if (RST)
                begin
                    port_gate_q[k]   <= `PORT_GATE_RESET;       // [R3]
                    serial_gate_q[k] <= `SERIAL_GATE_RESET;     // [R3]
                end
                else if (wr_go)
                begin
                    if (addr_q == port_ofs)
                        port_gate_q[k] <= HWDATA[7:0] & `PORT_GATE_MASK;        // [R8]
                    if (addr_q == serial_ofs)
                        serial_gate_q[k] <= HWDATA[15:0] & `SERIAL_GATE_MASK;   // [R13]
                end
            end
        end
    endgenerate

    always @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            auto_clock_gating_q <= `CONFIG_RESET;
            irq_mask_q          <= `IRQ_RESET;
        end
        else if (wr_go)
        begin
            if (addr_q == `RUN_CLOCK_CONFIG_OFS)
                auto_clock_gating_q <= HWDATA[`AUTO_CLOCK_GATING_BIT];  // [R5]
            if (addr_q == `IRQ_MASK_OFS)
                irq_mask_q <= HWDATA[`IRQ_BITS-1:0];
        end
    end

    // ****************************************
    // Mode selection and unit access check
    // ****************************************
    gate_select u_gate_select
    (
        .clk               (CLK_SYS),
        .rst               (RST),
        .sleep_mode        (SLEEP_MODE),
        .deep_sleep_mode   (DEEP_SLEEP_MODE),
        .auto_clock_gating (auto_clock_gating_q),
        .run_gate          ({serial_gate_q[0], port_gate_q[0]}),
        .sleep_gate        ({serial_gate_q[1], port_gate_q[1]}),
        .deep_gate         ({serial_gate_q[2], port_gate_q[2]}),
        .unit_en_q         (unit_en),
        .changed_q         (gate_changed)
    );

    // Unit ids: 0-7 ports, 8+n serial gate bit n
    access_check u_access_check
    (
        .clk     (CLK_SYS),
        .rst     (RST),
        .unit_en (unit_en),
        .req     (UNIT_REQ),
        .unit_id (UNIT_ID),
        .fault_q (fault),
        .done_q  (UNIT_DONE)
    );

    assign UNIT_FAULT = fault;                                   // [R2]

    // ****************************************
    // Clock enables
    // ****************************************
    assign PORT_CLK_EN           = unit_en[7:0];                 // [R1] [R8]
    assign TWO_WIRE_1_CLK_EN     = unit_en[8 + 14];              // [R9]
    assign TWO_WIRE_0_CLK_EN     = unit_en[8 + 12];              // [R9]
    assign QUAD_ENC_CLK_EN       = unit_en[8 + 8];               // [R10]
    assign SYNC_SERIAL_1_CLK_EN  = unit_en[8 + 5];               // [R11]
    assign SYNC_SERIAL_0_CLK_EN  = unit_en[8 + 4];               // [R11]
    assign ASYNC_SERIAL_2_CLK_EN = unit_en[8 + 2];               // [R12]
    assign ASYNC_SERIAL_1_CLK_EN = unit_en[8 + 1];               // [R12]
    assign ASYNC_SERIAL_0_CLK_EN = unit_en[8 + 0];               // [R12]

    // ****************************************
    // Interrupts
    // ****************************************
    always @*
    begin
        irq_event = {`IRQ_BITS{1'b0}};
        irq_event[`IRQ_ACCESS_FAULT_BIT] = fault;
        irq_event[`IRQ_GATE_CHANGE_BIT]  = gate_changed;
    end

    // Set wins over a same-cycle write-one clear
    always @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
            irq_status_q <= `IRQ_RESET;
        else if (wr_go && addr_q == `IRQ_STATUS_OFS)
            irq_status_q <= (irq_status_q & ~HWDATA[`IRQ_BITS-1:0]) | irq_event;
        else
            irq_status_q <= irq_status_q | irq_event;
    end

    assign IRQ = |(irq_status_q & irq_mask_q);

endmodule // clock_gate_ctrl

// File: clock_gate_ctrl_sva.sv
`timescale 1ns/1ps
`include "clock_gate_regs.vh"

module clock_gate_ctrl_check
(
    input wire                      CLK_SYS,
    input wire                      RST,
    input wire                      HSEL,
    input wire [1:0]                HTRANS,
    input wire                      HWRITE,
    input wire                      HREADY,
    input wire                      HREADYOUT,
    input wire                      UNIT_REQ,
    input wire [`UNIT_ID_WIDTH-1:0] UNIT_ID,
    input wire                      UNIT_FAULT,
    input wire                      UNIT_DONE,
    input wire [7:0]                PORT_CLK_EN,
    input wire                      TWO_WIRE_1_CLK_EN
);
    // ********************
    // Gating and bus checks
    // ********************
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    wire take = HSEL && HTRANS[1] && HREADY && HREADYOUT;

    answer_once_a: assert property (
        UNIT_REQ |=> UNIT_FAULT != UNIT_DONE) else $error("unit access answered wrongly");
    no_stray_answer_a: assert property (
        !UNIT_REQ |=> !UNIT_FAULT && !UNIT_DONE) else $error("answer without request");
    port_fault_a: assert property (
        UNIT_REQ && UNIT_ID < 8 && !PORT_CLK_EN[UNIT_ID[2:0]] |=> UNIT_FAULT)
        else $error("gated port access not faulted");
    port_done_a: assert property (
        UNIT_REQ && UNIT_ID < 8 && PORT_CLK_EN[UNIT_ID[2:0]] |=> UNIT_DONE)
        else $error("clocked port access not completed");
    two_wire_gate_a: assert property (
        UNIT_REQ && UNIT_ID == 22 |=> UNIT_DONE == $past(TWO_WIRE_1_CLK_EN))
        else $error("two-wire 1 access ignores its gate");
    reserved_fault_a: assert property (
        UNIT_REQ && (UNIT_ID >= 24 || UNIT_ID == 11) |=> UNIT_FAULT)
        else $error("unimplemented unit access not faulted");
    read_wait_a: assert property (
        take && !HWRITE |=> !HREADYOUT ##1 HREADYOUT) else $error("read wait state wrong");
    write_nowait_a: assert property (
        take && HWRITE |=> HREADYOUT ##1 (HREADYOUT || $past(take && !HWRITE)))
        else $error("write stalled");
endmodule // clock_gate_ctrl_check

bind clock_gate_ctrl clock_gate_ctrl_check check_u (.CLK_SYS(CLK_SYS), .RST(RST), .HSEL(HSEL),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HREADYOUT(HREADYOUT),
    .UNIT_REQ(UNIT_REQ), .UNIT_ID(UNIT_ID), .UNIT_FAULT(UNIT_FAULT), .UNIT_DONE(UNIT_DONE),
    .PORT_CLK_EN(PORT_CLK_EN), .TWO_WIRE_1_CLK_EN(TWO_WIRE_1_CLK_EN));

// File: peripheral_clock_gating_test.sv
`timescale 1ns/1ps
`include "clock_gate_regs.vh"

module peripheral_clock_gating_test;
    reg         CLK_SYS = 1'h0, RST = 1'h1, HSEL = 1'h0, HWRITE = 1'h0, UNIT_REQ = 1'h0;
    reg         SLEEP_MODE = 1'h0, DEEP_SLEEP_MODE = 1'h0;
    reg  [31:0] HADDR = 32'h0, HWDATA = 32'h0;
    reg  [1:0]  HTRANS = 2'h0;
    reg  [2:0]  HSIZE = 3'h2;
    reg  [4:0]  UNIT_ID = 5'h0;
    wire [31:0] HRDATA;
    wire [7:0]  PORT_CLK_EN;
    wire        HREADYOUT, HRESP, UNIT_FAULT, UNIT_DONE, IRQ, tw0, tw1, qe, ss0, ss1, as0, as1, as2;
    wire [23:0] en_vec = {1'h0, tw1, 1'h0, tw0, 3'h0, qe, 2'h0, ss1, ss0, 1'h0, as2, as1, as0,
                          PORT_CLK_EN};
    reg  [31:0] p, s, d;
    reg  [23:0] e_run, e_slp, e_dp;
    integer     i, j, m, n_errors = 0, n_compared = 0, cycles = 0;
    localparam bit [11:0] OFS [10] = '{`RUN_CLOCK_CONFIG_OFS, `RUN_PORT_GATE_OFS,
        `SLEEP_PORT_GATE_OFS, `DEEP_PORT_GATE_OFS, `RUN_SERIAL_GATE_OFS, `SLEEP_SERIAL_GATE_OFS,
        `DEEP_SERIAL_GATE_OFS, `IRQ_STATUS_OFS, `IRQ_MASK_OFS, 12'h300};

    clock_gate_ctrl dut_u (.CLK_SYS(CLK_SYS), .RST(RST), .HSEL(HSEL), .HADDR(HADDR),
        .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
        .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SLEEP_MODE(SLEEP_MODE),
        .DEEP_SLEEP_MODE(DEEP_SLEEP_MODE), .UNIT_REQ(UNIT_REQ), .UNIT_ID(UNIT_ID),
        .UNIT_FAULT(UNIT_FAULT), .UNIT_DONE(UNIT_DONE), .PORT_CLK_EN(PORT_CLK_EN),
        .TWO_WIRE_0_CLK_EN(tw0), .TWO_WIRE_1_CLK_EN(tw1), .QUAD_ENC_CLK_EN(qe),
        .SYNC_SERIAL_0_CLK_EN(ss0), .SYNC_SERIAL_1_CLK_EN(ss1), .ASYNC_SERIAL_0_CLK_EN(as0),
        .ASYNC_SERIAL_1_CLK_EN(as1), .ASYNC_SERIAL_2_CLK_EN(as2), .IRQ(IRQ));

    always #2 CLK_SYS = ~CLK_SYS;

    always @(posedge CLK_SYS)
    begin
        cycles = cycles + 1;
        if (cycles == 6000)
        begin
            n_errors = n_errors + 1;
            wrap_up;
        end
    end

    // ******************
    // Bus and check tasks
    // ******************
    function [23:0] gates(input [31:0] pv, input [31:0] sv);
        gates = {sv[15:0] & `SERIAL_GATE_MASK, pv[7:0] & `PORT_GATE_MASK};
    endfunction

    task check(input [31:0] got, input [31:0] exp);
        n_compared = n_compared + 1;
        if (got !== exp)
        begin
            n_errors = n_errors + 1;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task ahb(input wr, input [11:0] ofs, input [31:0] wd, output [31:0] rd);
        HSEL <= 1'h1;
        HTRANS <= 2'h2;
        HWRITE <= wr;
        HADDR <= {20'h0, ofs};
        @(posedge CLK_SYS);
        while (!HREADYOUT) @(posedge CLK_SYS);
        HTRANS <= 2'h0;
        if (wr) HWDATA <= wd;
        @(posedge CLK_SYS);
        while (!HREADYOUT) @(posedge CLK_SYS);
        rd = HRDATA;
    endtask

    task wr(input [11:0] ofs, input [31:0] wd);
        ahb(1'h1, ofs, wd, d);
    endtask

    task rd_chk(input [11:0] ofs, input [31:0] exp);
        ahb(1'h0, ofs, 32'h0, d);
        check(d, exp);
        check(HRESP, 32'h0);
    endtask

    task settle;
        repeat (2) @(posedge CLK_SYS);
    endtask

    task unit(input [4:0] id, input [23:0] en);
        @(posedge CLK_SYS);
        UNIT_REQ <= 1'h1;
        UNIT_ID <= id;
        @(posedge CLK_SYS);
        UNIT_REQ <= 1'h0;
        @(posedge CLK_SYS);
        check({UNIT_FAULT, UNIT_DONE}, (id >= 24 || !en[id]) ? 32'h2 : 32'h1);
    endtask

    task wrap_up;
        $display("Comparisons %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ********
    // Sequence
    // ********
    initial
    begin
        void'($urandom(17011));
        repeat (10) @(posedge CLK_SYS);
        RST <= 1'h0;
        @(posedge CLK_SYS);
        check(en_vec, 32'h0);
        for (i = 0; i < 10; i++) rd_chk(OFS[i], 32'h0);
        for (i = 0; i < 8; i++)
        begin
            p = (i == 0) ? 32'hFFFFFFFF : $urandom;
            s = (i == 0) ? 32'hFFFFFFFF : $urandom;
            wr(`RUN_PORT_GATE_OFS, p);
            wr(`RUN_SERIAL_GATE_OFS, s);
            e_run = gates(p, s);
            rd_chk(`RUN_PORT_GATE_OFS, p & 32'h000000FF);
            rd_chk(`RUN_SERIAL_GATE_OFS, s & 32'h00005137);
            settle;
            check(en_vec, e_run);
            for (j = i; j < 32; j += 8) unit(j[4:0], e_run);
        end
        p = $urandom;
        s = $urandom;
        wr(`SLEEP_PORT_GATE_OFS, p);
        wr(`SLEEP_SERIAL_GATE_OFS, s);
        e_slp = gates(p, s);
        rd_chk(`SLEEP_PORT_GATE_OFS, {24'h0, e_slp[7:0]});
        rd_chk(`SLEEP_SERIAL_GATE_OFS, {16'h0, e_slp[23:8]});
        p = $urandom;
        s = $urandom;
        wr(`DEEP_PORT_GATE_OFS, p);
        wr(`DEEP_SERIAL_GATE_OFS, s);
        e_dp = gates(p, s);
        rd_chk(`DEEP_PORT_GATE_OFS, {24'h0, e_dp[7:0]});
        rd_chk(`DEEP_SERIAL_GATE_OFS, {16'h0, e_dp[23:8]});
        for (m = 0; m < 8; m++)
        begin
            wr(`RUN_CLOCK_CONFIG_OFS, {31'h0, m[2]});
            SLEEP_MODE <= m[0];
            DEEP_SLEEP_MODE <= m[1];
            settle;
            check(en_vec, !m[2] ? e_run : m[1] ? e_dp : m[0] ? e_slp : e_run);
            unit(5'h7, !m[2] ? e_run : m[1] ? e_dp : m[0] ? e_slp : e_run);
        end
        SLEEP_MODE <= 1'h0;
        DEEP_SLEEP_MODE <= 1'h0;
        settle;
        check(IRQ, 32'h0);
        rd_chk(`IRQ_STATUS_OFS, 32'h3);
        wr(`IRQ_MASK_OFS, 32'h1);
        settle;
        check(IRQ, 32'h1);
        wr(`IRQ_STATUS_OFS, 32'h1);
        settle;
        check(IRQ, 32'h0);
        rd_chk(`IRQ_STATUS_OFS, 32'h2);
        wr(`IRQ_MASK_OFS, 32'h2);
        settle;
        check(IRQ, 32'h1);
        wr(`IRQ_STATUS_OFS, 32'h2);
        settle;
        check(IRQ, 32'h0);
        RST <= 1'h1;
        @(posedge CLK_SYS);
        #1;
        check(en_vec, 32'h0);
        @(posedge CLK_SYS);
        RST <= 1'h0;
        @(posedge CLK_SYS);
        rd_chk(`RUN_PORT_GATE_OFS, 32'h0);
        rd_chk(`IRQ_STATUS_OFS, 32'h0);
        check(IRQ, 32'h0);
        wrap_up;
    end
endmodule // peripheral_clock_gating_test
